/* File: logic/cgr_map.svh */
`ifndef CGR_MAP_SVH
`define CGR_MAP_SVH
`define OSC_DIV_CTRL_ADDR  8'hDC
`define CTRL_ADDR          8'hE0
`define STATUS_ADDR        8'hE4
`define OSC_DIV_RESET      8'h00
`define DIV_SEL_LSB        0
`define DIV_SEL_MSB        1
`define DIV_RSVD3_BIT      3
`define CTRL_OSC_OFF_BIT   0
// guard: minimum bus-clock ticks between two passed edges
`define GUARD_MIN_GAP      4'h4
// main edge missing after this many ticks means failure
`define MISS_LIMIT         4'hF
// backup oscillator: one enable every 16 ticks
`define BACKUP_DIV         4'hF
// stabilisation delay, in guard ticks taken before the divider
`define STAB_COUNT         12'hFFF
`define LVD_RISE_THR       8'hA0
`define LVD_FALL_THR       8'h90
`endif

/* File: logic/cgr_pkg.sv */
package cgr_pkg;
  typedef enum logic [1:0] {
    CLK_MAIN   = 2'b00,
    CLK_BACKUP = 2'b01
  } clk_src_e;
endpackage

/* File: logic/clock_guard.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cgr_map.svh"
module clock_guard (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // sampled oscillator and control
  input  wire logic       osc_in_s,
  input  wire logic       guard_en,
  input  wire logic       main_osc_off,
  // conditioned edge enable and status
  output logic            tick,
  output logic            on_backup
);
  logic       osc_d;
  logic [3:0] gap;
  logic [3:0] miss;
  logic [3:0] bdiv;
  logic       rise;
  logic       next_tick;
  assign rise = osc_in_s & ~osc_d & ~main_osc_off;

  // pass decision; one spacing counter covers main and backup edges
  // so a source switch cannot squeeze two ticks together
  always_comb begin
    if (on_backup)
      next_tick = (bdiv == `BACKUP_DIV) && (gap == `GUARD_MIN_GAP);
    else if (guard_en) next_tick = rise && (gap == `GUARD_MIN_GAP);
    else next_tick = rise;
  end

  // edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) osc_d <= 1'b0;
    else          osc_d <= osc_in_s;
  end

  // spacing and missing-edge counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap  <= 4'h0;
      miss <= 4'h0;
    end else begin
      if (rise) miss <= 4'h0;
      else if (miss != `MISS_LIMIT) miss <= miss + 4'h1;
      // restart spacing at the passed edge itself
      if (next_tick) gap <= 4'h1;
      else if (gap != `GUARD_MIN_GAP) gap <= gap + 4'h1;
    end
  end

  // backup selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) on_backup <= 1'b0;
    else if (guard_en && (main_osc_off || miss == `MISS_LIMIT))
      on_backup <= 1'b1;
    else if (rise) on_backup <= 1'b0;
  end

  // output edge enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
      bdiv <= 4'h0;
    end else begin
      bdiv <= (bdiv == `BACKUP_DIV) ? 4'h0 : bdiv + 4'h1;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* File: logic/stab_delay.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cgr_map.svh"
module stab_delay (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       restart,
  input  wire logic       step,
  // status
  output logic            done
);
  logic [11:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 12'h000;
      done <= 1'b0;
    end else if (restart) begin
      cnt  <= 12'h000;
      done <= 1'b0;
    end else if (step && !done) begin
      cnt  <= cnt + 12'h001;
      done <= (cnt == `STAB_COUNT - 12'h001);
    end
  end
endmodule
`default_nettype wire

/* File: logic/clock_guard_and_reset_unit.sv */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cgr_map.svh"
module clock_guard_and_reset_unit (
  // ahb-lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // programming-time options
  input  wire logic        opt_guard_en,
  input  wire logic        opt_lvd_en,
  // pins and analog detector inputs
  input  wire logic        osc_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic        por_detect,
  input  wire logic        watchdog_end,
  input  wire logic [7:0]  supply_level,
  // reset pin drive
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  // clock and reset outputs
  output logic             internal_clk_en,
  output logic             internal_reset,
  output logic             io_pullup_inputs,
  output logic             main_osc_enable,
  output logic             backup_osc_active,
  output logic             watchdog_clear,
  output logic [1:0]       clk_source
);
  // synchronisers
  logic [1:0] osc_sync;
  logic [1:0] pin_sync;
  logic [1:0] por_sync;
  logic [1:0] wdg_sync;
  logic [7:0] lvl_s1;
  logic [7:0] lvl_s2;
  // register state
  logic [7:0] osc_div_ctrl;
  logic       main_osc_off;
  // bus pipeline
  logic       ph_valid;
  logic       ph_write;
  logic [7:0] ph_addr;
  // reset and clock state
  logic       lvd_low;
  logic       any_src;
  logic       int_src;
  logic       tick;
  logic       on_backup;
  logic       stab_done;
  logic [1:0] div_cnt;
  logic       div_tick;
  logic       osc_off_eff;

  // divider ratio from select field
  function automatic logic [1:0] div_mask(input logic [1:0] sel);
    unique case (sel)
      2'b00:   div_mask = 2'b00;
      2'b01:   div_mask = 2'b01;
      2'b10:   div_mask = 2'b11;
      2'b11:   div_mask = 2'b11;
    endcase
  endfunction

  // two-flop synchronisers for pins and external detectors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_sync <= 2'b00;
      pin_sync <= 2'b11;
      por_sync <= 2'b00;
      wdg_sync <= 2'b00;
      lvl_s1   <= 8'h00;
      lvl_s2   <= 8'h00;
    end else begin
      osc_sync <= {osc_sync[0], osc_in};
      pin_sync <= {pin_sync[0], reset_pin_n_in};
      por_sync <= {por_sync[0], por_detect};
      wdg_sync <= {wdg_sync[0], watchdog_end};
      lvl_s1   <= supply_level;
      lvl_s2   <= lvl_s1;
    end
  end

  // low-voltage detector with hysteresis
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lvd_low <= 1'b1;
    else if (lvd_low && lvl_s2 >= `LVD_RISE_THR) lvd_low <= 1'b0;
    else if (!lvd_low && lvl_s2 < `LVD_FALL_THR) lvd_low <= 1'b1;
  end

  assign int_src = por_sync[1] | wdg_sync[1] | (opt_lvd_en & lvd_low);
  assign any_src = int_src | ~pin_sync[1];

  assign osc_off_eff = main_osc_off & opt_guard_en;

  clock_guard u_guard (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .osc_in_s     (osc_sync[1]),
    .guard_en     (opt_guard_en),
    .main_osc_off (osc_off_eff),
    .tick         (tick),
    .on_backup    (on_backup)
  );

  // programmable divider on the conditioned clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt  <= 2'b00;
      div_tick <= 1'b0;
    end else if (tick) begin
      if ((div_cnt & div_mask(osc_div_ctrl[`DIV_SEL_MSB:`DIV_SEL_LSB]))
          == div_mask(osc_div_ctrl[`DIV_SEL_MSB:`DIV_SEL_LSB])) begin
        div_cnt  <= 2'b00;
        div_tick <= 1'b1;
      end else begin
        div_cnt  <= div_cnt + 2'b01;
        div_tick <= 1'b0;
      end
    end else begin
      div_tick <= 1'b0;
    end
  end

  stab_delay u_stab (
    .hclk    (hclk),
    .hresetn (hresetn),
    .restart (any_src),
    .step    (tick),
    .done    (stab_done)
  );

  // reset, pin and clock outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_reset    <= 1'b1;
      io_pullup_inputs  <= 1'b1;
      reset_pin_out     <= 1'b0;
      reset_pin_oe      <= 1'b1;
      watchdog_clear    <= 1'b1;
      main_osc_enable   <= 1'b1;
      backup_osc_active <= 1'b0;
      internal_clk_en   <= 1'b0;
      clk_source        <= cgr_pkg::CLK_MAIN;
    end else begin
      internal_reset   <= any_src | ~stab_done;
      io_pullup_inputs <= any_src | ~stab_done;
      reset_pin_out    <= 1'b0;
      reset_pin_oe     <= int_src;
      watchdog_clear   <= any_src | ~stab_done;
      main_osc_enable  <= any_src | ~osc_off_eff;
      backup_osc_active <= on_backup;
      internal_clk_en  <= div_tick;
      clk_source       <= on_backup ? cgr_pkg::CLK_BACKUP
                                    : cgr_pkg::CLK_MAIN;
    end
  end

  // ahb-lite address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel & htrans[1];
      ph_write <= hwrite;
      ph_addr  <= haddr[7:0];
    end
  end

  // register writes, data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_div_ctrl <= `OSC_DIV_RESET;
      main_osc_off <= 1'b0;
    end else if (any_src) begin
      osc_div_ctrl <= `OSC_DIV_RESET;
      main_osc_off <= 1'b0;
    end else if (ph_valid && ph_write) begin
      if (ph_addr == `OSC_DIV_CTRL_ADDR)
        osc_div_ctrl <= hwdata[7:0];
      if (ph_addr == `CTRL_ADDR)
        main_osc_off <= hwdata[`CTRL_OSC_OFF_BIT];
    end
  end

  // read data; divider register is write-only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `CTRL_ADDR:   hrdata <= {31'h0000_0000, main_osc_off};
        `STATUS_ADDR: hrdata <= {27'h000_0000, lvd_low, stab_done,
                                 ~osc_off_eff, on_backup, internal_reset};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // zero-wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/cgr_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cgr_checker (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // options and reset sources
  input wire logic       opt_guard_en,
  input wire logic       opt_lvd_en,
  input wire logic       reset_pin_n_in,
  input wire logic       por_detect,
  input wire logic       watchdog_end,
  input wire logic [7:0] supply_level,
  // reset and clock outputs
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe,
  input wire logic       internal_clk_en,
  input wire logic       internal_reset,
  input wire logic       io_pullup_inputs,
  input wire logic       watchdog_clear
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // five samples carry a level through the input synchronisers
  sequence s_wdog;
    watchdog_end [*5];
  endsequence
  a_wdog_resets:
    assert property (s_wdog |-> internal_reset && watchdog_clear && reset_pin_oe)
    else $error("watchdog reset missing");
  a_wdog_delay:
    assert property (s_wdog ##1 !watchdog_end |-> internal_reset [*8])
    else $error("reset left early");
  a_por_drive:
    assert property (por_detect [*5] |-> internal_reset && reset_pin_oe)
    else $error("power-on reset missing");
  a_lvd_hold:
    assert property ((opt_lvd_en && supply_level < 8'h90) [*5]
      |-> internal_reset && reset_pin_oe)
    else $error("low supply reset missing");
  a_pin_holds:
    assert property (!reset_pin_n_in [*5] |-> internal_reset)
    else $error("pin reset not held");
  a_pin_low:
    assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  a_pullup_io:
    assert property (io_pullup_inputs == internal_reset)
    else $error("pull-up state wrong");
  a_guard_gap:
    assert property (opt_guard_en && internal_clk_en |=> !internal_clk_en [*3])
    else $error("clock above guard rate");
endmodule
bind clock_guard_and_reset_unit cgr_checker cgr_checker_i (
  .hclk, .hresetn, .opt_guard_en, .opt_lvd_en, .reset_pin_n_in,
  .por_detect, .watchdog_end, .supply_level, .reset_pin_out,
  .reset_pin_oe, .internal_clk_en, .internal_reset, .io_pullup_inputs,
  .watchdog_clear
);
`default_nettype wire

/* File: test/board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module board_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // oscillator controls
  input  wire logic [1:0] half,
  input  wire logic       run,
  // oscillator pin
  output logic            osc_in
);
  logic [1:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_in <= 1'b0;
      cnt    <= 2'h0;
    end else if (!run) begin
      osc_in <= 1'b0;
      cnt    <= 2'h0;
    end else if (cnt == half - 2'h1) begin
      osc_in <= !osc_in;
      cnt    <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, osc_in, run_b, reset_pin_n_in;
  logic        por_detect, watchdog_end, hresp, hreadyout, reset_pin_out;
  logic        reset_pin_oe, internal_clk_en, internal_reset, watchdog_clear;
  logic        io_pullup_inputs, main_osc_enable, backup_osc_active;
  logic        opt_guard;
  logic [1:0]  htrans, half, clk_source, s;
  logic [7:0]  supply_level;
  logic [31:0] haddr, hwdata, hrdata, q, seed, div_shadow;
  int          err_total, samples_checked, cyc, i;
  clock_guard_and_reset_unit clock_guard_and_reset_unit_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .opt_guard_en(opt_guard), .opt_lvd_en(1'b1), .osc_in, .reset_pin_n_in,
    .por_detect, .watchdog_end, .supply_level, .reset_pin_out,
    .reset_pin_oe, .internal_clk_en, .internal_reset, .io_pullup_inputs,
    .main_osc_enable, .backup_osc_active, .watchdog_clear, .clk_source
  );
  board_model board_model_i (
    .hclk, .hresetn, .half, .run(run_b && main_osc_enable), .osc_in
  );
  // bus clock
  always #12.5 hclk = !hclk;
  task automatic chk(input string nm, input logic [31:0] e, v);
    samples_checked++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, v);
    end
  endtask
  // wait at sampling edges until a level shows
  task automatic wait_for(ref logic sig, input logic v);
    do @(posedge hclk); while (sig !== v);
  endtask
  // one single word transfer; read data lands in q
  task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_for(hreadyout, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(hreadyout, 1'b1);
    q = hrdata;
  endtask
  // second of two spacings between internal clock pulses
  task automatic gap_is(input logic [31:0] e);
    int n;
    repeat (2) begin
      n = 0;
      wait_for(internal_clk_en, 1'b1);
      do begin
        @(posedge hclk);
        n++;
      end while (internal_clk_en !== 1'b1);
    end
    chk("clock gap", e, n);
  endtask
  function automatic logic [31:0] exp_gap(input logic [1:0] c);
    exp_gap = c == 2'h0 ? 32'h4 : c == 2'h1 ? 32'h8 : 32'h10;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] t;
    t = x ^ (x << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, por_detect, watchdog_end} = '0;
    {htrans, haddr, hwdata} = '0;
    {reset_pin_n_in, run_b} = 2'h3;
    opt_guard = 1'b1;
    half = 2'h2;
    supply_level = 8'hC0;
    seed = 32'h9111554F;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    wait_for(internal_reset, 1'b0);
    bus(1'b0, 8'hE4, 32'h0);
    chk("status", 32'h0C, q);
    bus(1'b0, 8'hDC, 32'h0);
    chk("divider read", 32'h0, q);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, q);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      s = i < 4 ? 2'(i) : seed[9:8];
      div_shadow = {24'h0, seed[7:4], 2'h0, s};
      bus(1'b1, 8'hDC, div_shadow);
      gap_is(exp_gap(div_shadow[1:0]));
    end
    bus(1'b1, 8'hDC, 32'h0);
    half <= 2'h1;
    gap_is(32'h4);
    half <= 2'h2;
    run_b <= 1'b0;
    wait_for(backup_osc_active, 1'b1);
    gap_is(32'h10);
    chk("source", 32'h1, clk_source);
    run_b <= 1'b1;
    wait_for(backup_osc_active, 1'b0);
    bus(1'b1, 8'hE0, 32'h1);
    wait_for(backup_osc_active, 1'b1);
    chk("osc enable", 32'h0, main_osc_enable);
    bus(1'b1, 8'hE0, 32'h0);
    wait_for(backup_osc_active, 1'b0);
    gap_is(32'h4);
    chk("source", 32'h0, clk_source);
    supply_level <= 8'h98;
    repeat (8) @(posedge hclk);
    bus(1'b0, 8'hE4, 32'h0);
    chk("supply flags", 32'h0, q & 32'h11);
    supply_level <= 8'h88;
    wait_for(internal_reset, 1'b1);
    bus(1'b1, 8'hDC, 32'h2);
    supply_level <= 8'h98;
    repeat (8) @(posedge hclk);
    bus(1'b0, 8'hE4, 32'h0);
    chk("supply flags", 32'h11, q & 32'h11);
    supply_level <= 8'hC0;
    for (i = 0; i < 3; i++) begin
      reset_pin_n_in <= i != 0;
      watchdog_end <= i == 1;
      por_detect <= i == 2;
      repeat (8) @(posedge hclk);
      chk("reset level", 32'h1, internal_reset);
      chk("pull-up", 32'h1, io_pullup_inputs);
      chk("pin drive", i != 0 ? 32'h1 : 32'h0, reset_pin_oe);
    end
    {reset_pin_n_in, watchdog_end, por_detect} <= 3'h4;
    wait_for(internal_reset, 1'b0);
    gap_is(32'h4);
    // guard option off across a reset
    hresetn <= 1'b0;
    opt_guard <= 1'b0;
    half <= 2'h1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    gap_is(32'h2);
    complete_run();
  end
endmodule
`default_nettype wire
